// >>> common/sli_pkg.sv
// Package of constants and types for the status lamp logic.
package sli_pkg;
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned SECOND_NS        = 1_000_000_000;
    localparam int unsigned CLK_PERIOD_NS    = SECOND_NS / CLK_HZ;
    localparam int unsigned TICK_CYCLES      = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_ON_S       = 1;
    localparam int unsigned PULSE_OFF_S      = 1;
    localparam int unsigned PAUSE_S          = 5;
    localparam int unsigned START_PWR_FLASH  = 3;
    localparam int unsigned NET_STEP_S       = 1;
    localparam logic [2:0]  NET_CODE_NONE    = 3'h0;
    localparam logic [2:0]  NET_CODE_MAX     = 3'h6;
    localparam logic [1:0]  ERR_NONE         = 2'h0;
    localparam logic [1:0]  ERR_100          = 2'h1;
    localparam logic [1:0]  ERR_200          = 2'h2;
    localparam logic [1:0]  ERR_SEVERE       = 2'h3;
    localparam logic        DI_FAILSAFE_RST  = 1'b0;
    localparam logic        DI_LATCH_RST     = 1'b0;
    localparam logic        DI_FILTER_RST    = 1'b0;
    localparam logic        DI_ACTIVE_RST    = 1'b1;

    typedef enum logic [2:0] {
        SLI_START_A,
        SLI_START_B,
        SLI_START_C,
        SLI_START_D,
        SLI_RUN
    } sli_ctl_state_t;

    typedef enum logic [2:0] {
        SLI_NET_S1,
        SLI_NET_S2,
        SLI_NET_S3,
        SLI_NET_S4,
        SLI_NET_LIVE
    } sli_net_state_t;
endpackage : sli_pkg

// >>> core/sli_tick.sv
// Free-running one-second tick divider with a blink phase.
`timescale 1ns/1ps
`default_nettype none
module sli_tick #(
    parameter int unsigned CYCLES = sli_pkg::TICK_CYCLES
) (
    input  wire logic clk_i,    // System clock.
    input  wire logic reset_i,  // Synchronous reset.
    output logic      tick_o,   // One-cycle pulse each second.
    output logic      phase_o   // Toggles each second: blink level.
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count;
    wire          wrap = (count == W'(CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count   <= '0;
            tick_o  <= 1'b0;
            phase_o <= 1'b0;
        end else begin
            count  <= wrap ? '0 : count + W'(1);
            tick_o <= wrap;
            if (wrap) begin
                phase_o <= ~phase_o;
            end
        end
    end

    property p_tick_period;
        @(posedge clk_i) disable iff (reset_i)
        tick_o |=> !tick_o;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick wider than one cycle");

    property p_phase_on_tick;
        @(posedge clk_i) disable iff (reset_i)
        !tick_o |=> $stable(phase_o) || $past(wrap);
    endproperty
    a_phase_on_tick: assert property (p_phase_on_tick) else $error("phase moved off tick");
endmodule : sli_tick
`default_nettype wire

// >>> core/sli_lamps.sv
// Status lamp logic for controller, network board and I/O module channels.
`timescale 1ns/1ps
`default_nettype none
module sli_lamps #(
    parameter int unsigned TICK_CYCLES = sli_pkg::TICK_CYCLES,
    parameter int unsigned CHANNELS    = 8
) (
    input  wire logic                clk_i,            // System clock.
    input  wire logic                reset_i,          // Synchronous reset.
    input  wire logic [1:0]          err_class_i,      // Controller error class.
    input  wire logic                cpu_ready_i,      // Processor initialised.
    input  wire logic                comm_ok_i,        // Module communication up.
    input  wire logic                module_fail_i,    // A module missing or failed.
    input  wire logic [6:0]          module_slot_i,    // Suspect module slot.
    input  wire logic                enter_i,          // Enter key pulse.
    input  wire logic                link_up_i,        // Network link present.
    input  wire logic                link_act_i,       // Network traffic seen.
    input  wire logic                full_duplex_i,    // Link is full duplex.
    input  wire logic                speed100_i,       // Link is 100 Mb.
    input  wire logic                net_test_done_i,  // Network self-test over.
    input  wire logic [2:0]          net_err_code_i,   // Failing test, 0 none.
    input  wire logic                mod_failsafe_i,   // Module in fail-safe.
    input  wire logic                mod_fault_i,      // Module fault.
    input  wire logic                mod_addr_err_i,   // Module address error.
    input  wire logic                mod_startup_i,    // Module start-up mode.
    input  wire logic [CHANNELS-1:0] ai_good_i,        // AI loop good.
    input  wire logic [CHANNELS-1:0] ai_active_i,      // AI channel active.
    input  wire logic [CHANNELS-1:0] ai_err_i,         // AI HART or converter error.
    input  wire logic [CHANNELS-1:0] ao_good_i,        // AO loop good.
    input  wire logic [CHANNELS-1:0] ao_active_i,      // AO channel active.
    input  wire logic [CHANNELS-1:0] ao_err_i,         // AO error.
    input  wire logic [CHANNELS-1:0] di_level_i,       // DI input level.
    input  wire logic [CHANNELS-1:0] di_latch_en_i,    // DI latch enable request.
    input  wire logic [CHANNELS-1:0] do_level_i,       // DO output level.
    input  wire logic [CHANNELS-1:0] do_active_i,      // DO channel active.
    output logic                     power_ok_lamp_o,  // Green power lamp.
    output logic                     red_lamp_o,       // Red status lamp.
    output logic                     yellow_lamp_o,    // Yellow status lamp.
    output logic                     err_clear_o,      // Clear pending error pulse.
    output logic                     outputs_frozen_o, // Module outputs frozen.
    output logic                     module_no_comm_message_o, // Show no-comm message.
    output logic [3:0]               slot_tens_o,      // Slot digit, tens.
    output logic [3:0]               slot_ones_o,      // Slot digit, ones.
    output logic                     act_lamp_o,       // Network activity lamp.
    output logic                     duplex_lamp_o,    // Full duplex lamp.
    output logic                     speed_lamp_o,     // 100 Mb lamp.
    output logic                     selftest_lamp_o,  // Network self-test lamp.
    output logic                     net_green_lamp_o, // Protocol green lamp.
    output logic                     net_red_lamp_o,   // Protocol red lamp.
    output logic                     fault_lamp_o,     // Module fault lamp.
    output logic [CHANNELS-1:0]      ai_lamp_o,        // AI channel lamps.
    output logic [CHANNELS-1:0]      ao_lamp_o,        // AO channel lamps.
    output logic [CHANNELS-1:0]      di_lamp_o,        // DI channel lamps.
    output logic [CHANNELS-1:0]      do_lamp_o,        // DO channel lamps.
    output logic                     di_failsafe_o,    // DI module fail-safe mode.
    output logic [CHANNELS-1:0]      di_active_o       // DI channels active.
);
    ////////////////////////////////////////////////////////////////////////
    // Shared one-second tick and blink phase.
    logic tick;
    logic blink;

    sli_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .tick_o  (tick),
        .phase_o (blink)
    );

    ////////////////////////////////////////////////////////////////////////
    // Controller start-up: red lamp on, off, on, off, then run.
    sli_pkg::sli_ctl_state_t ctl_state;
    sli_pkg::sli_ctl_state_t next_ctl_state;
    logic [1:0]              pwr_flashes;
    logic                    err_pending;
    logic                    err200_q;

    always_comb begin
        next_ctl_state = ctl_state;
        case (ctl_state)
            sli_pkg::SLI_START_A: next_ctl_state = sli_pkg::SLI_START_B;
            sli_pkg::SLI_START_B: next_ctl_state = sli_pkg::SLI_START_C;
            sli_pkg::SLI_START_C: next_ctl_state = sli_pkg::SLI_START_D;
            sli_pkg::SLI_START_D: next_ctl_state = sli_pkg::SLI_RUN;
            sli_pkg::SLI_RUN:     next_ctl_state = sli_pkg::SLI_RUN;
            default:              next_ctl_state = sli_pkg::SLI_START_A;
        endcase
    end

    wire in_start   = (ctl_state != sli_pkg::SLI_RUN);
    wire start_red  = (ctl_state == sli_pkg::SLI_START_A) ||
                      (ctl_state == sli_pkg::SLI_START_C);
    wire err200     = (err_class_i == sli_pkg::ERR_200);
    // Blinking is a state, so a key press in the dark half of a blink still clears.
    wire red_blink  = !in_start && err200 && err_pending;
    wire clear_now  = enter_i && red_blink;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl_state   <= sli_pkg::SLI_START_A;
            pwr_flashes <= 2'h0;
            err_pending <= 1'b0;
            err_clear_o <= 1'b0;
            err200_q    <= 1'b0;
        end else begin
            if (tick) begin
                ctl_state <= next_ctl_state;
            end
            if (tick && !cpu_ready_i && pwr_flashes != 2'(sli_pkg::START_PWR_FLASH)) begin
                pwr_flashes <= pwr_flashes + 2'h1;
            end
            // A new error in the same cycle as the clear keeps the flag set.
            err200_q <= err200;
            if (err200 && !err200_q) begin
                err_pending <= 1'b1;
            end else if (clear_now) begin
                err_pending <= 1'b0;
            end
            err_clear_o <= clear_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller lamps.
    wire pwr_init_blink = !cpu_ready_i &&
                          pwr_flashes != 2'(sli_pkg::START_PWR_FLASH);
    wire next_power = (err_class_i == sli_pkg::ERR_SEVERE) ? 1'b0 :
                      pwr_init_blink ? blink : 1'b1;
    wire next_red   = in_start ? start_red :
                      (err_class_i == sli_pkg::ERR_100) ? 1'b1 :
                      red_blink ? blink : 1'b0;
    wire offline    = (err_class_i != sli_pkg::ERR_NONE);
    wire next_yel   = (!cpu_ready_i || !comm_ok_i) && !module_fail_i ? blink :
                      offline ? 1'b0 :
                      module_fail_i ? blink : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Network board: power-up sequence, link lamps, error pulse code.
    sli_pkg::sli_net_state_t net_state;
    logic [2:0]              pulse_cnt;
    logic [2:0]              pause_cnt;
    logic                    pulse_on;

    wire net_live = (net_state == sli_pkg::SLI_NET_LIVE);
    wire net_err  = (net_err_code_i != sli_pkg::NET_CODE_NONE) &&
                    (net_err_code_i <= sli_pkg::NET_CODE_MAX);
    wire in_pause = (pause_cnt != 3'h0);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            net_state <= sli_pkg::SLI_NET_S1;
            pulse_cnt <= 3'h0;
            pause_cnt <= 3'h0;
            pulse_on  <= 1'b0;
        end else if (tick) begin
            case (net_state)
                sli_pkg::SLI_NET_S1: net_state <= sli_pkg::SLI_NET_S2;
                sli_pkg::SLI_NET_S2: net_state <= sli_pkg::SLI_NET_S3;
                sli_pkg::SLI_NET_S3: net_state <= net_test_done_i ? sli_pkg::SLI_NET_S4
                                                                  : sli_pkg::SLI_NET_S3;
                sli_pkg::SLI_NET_S4: net_state <= sli_pkg::SLI_NET_LIVE;
                default:             net_state <= sli_pkg::SLI_NET_LIVE;
            endcase
            if (!net_err) begin
                pulse_cnt <= 3'h0;
                pause_cnt <= 3'h0;
                pulse_on  <= 1'b0;
            end else if (in_pause) begin
                pause_cnt <= pause_cnt - 3'h1;
                pulse_on  <= (pause_cnt == 3'h1);
            end else if (pulse_on) begin
                pulse_on  <= 1'b0;
                pulse_cnt <= pulse_cnt + 3'h1;
            end else if (pulse_cnt >= net_err_code_i) begin
                // The off second after the last pulse is over, so the pause starts.
                pulse_cnt <= 3'h0;
                pause_cnt <= 3'(sli_pkg::PAUSE_S);
            end else begin
                pulse_on <= 1'b1;
            end
        end
    end

    wire next_act = !net_live ? (net_state == sli_pkg::SLI_NET_S2) :
                    !link_up_i ? 1'b0 : link_act_i ? blink : 1'b1;
    wire next_st  = (net_state == sli_pkg::SLI_NET_S1) ||
                    (net_state == sli_pkg::SLI_NET_S3) ||
                    (net_live && !net_test_done_i);
    wire next_ngr = (net_state != sli_pkg::SLI_NET_S2);
    wire next_nrd = (net_state == sli_pkg::SLI_NET_S1) ||
                    (net_state == sli_pkg::SLI_NET_S2) ||
                    (net_live && pulse_on && !in_pause);

    ////////////////////////////////////////////////////////////////////////
    // Slot number as two decimal digits.
    wire [6:0] slot_lim  = (module_slot_i > 7'h63) ? 7'h63 : module_slot_i;
    wire [3:0] next_tens = 4'(slot_lim / 7'h0A);
    wire [3:0] next_ones = 4'(slot_lim % 7'h0A);

    ////////////////////////////////////////////////////////////////////////
    // I/O module channel lamps, one slice per channel.
    logic [CHANNELS-1:0] di_latched;
    logic [CHANNELS-1:0] di_latch_en;
    wire  next_fault = (mod_addr_err_i || mod_startup_i) ? blink :
                       (mod_failsafe_i || mod_fault_i);

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                ai_lamp_o[c]   <= 1'b0;
                ao_lamp_o[c]   <= 1'b0;
                di_lamp_o[c]   <= 1'b0;
                do_lamp_o[c]   <= 1'b0;
                di_latched[c]  <= 1'b0;
                di_latch_en[c] <= sli_pkg::DI_LATCH_RST;
                di_active_o[c] <= sli_pkg::DI_ACTIVE_RST;
            end else begin
                ai_lamp_o[c] <= ai_good_i[c] && !ai_err_i[c] ? 1'b1 :
                                (ai_active_i[c] || ai_err_i[c]) ? blink : 1'b0;
                ao_lamp_o[c] <= ao_good_i[c] && !ao_err_i[c] ? 1'b1 :
                                (ao_active_i[c] || ao_err_i[c]) ? blink : 1'b0;
                di_latch_en[c] <= di_latch_en_i[c];
                di_latched[c]  <= di_latch_en[c] && (di_latched[c] || di_level_i[c]);
                di_lamp_o[c]   <= di_level_i[c] || di_latched[c];
                do_lamp_o[c]   <= do_active_i[c] && do_level_i[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered lamp and message outputs.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            power_ok_lamp_o          <= 1'b0;
            red_lamp_o               <= 1'b0;
            yellow_lamp_o            <= 1'b0;
            outputs_frozen_o         <= 1'b0;
            module_no_comm_message_o <= 1'b0;
            slot_tens_o              <= 4'h0;
            slot_ones_o              <= 4'h0;
            act_lamp_o               <= 1'b0;
            duplex_lamp_o            <= 1'b0;
            speed_lamp_o             <= 1'b0;
            selftest_lamp_o          <= 1'b0;
            net_green_lamp_o         <= 1'b0;
            net_red_lamp_o           <= 1'b0;
            fault_lamp_o             <= 1'b0;
            di_failsafe_o            <= sli_pkg::DI_FAILSAFE_RST;
        end else begin
            power_ok_lamp_o          <= next_power;
            red_lamp_o               <= next_red;
            yellow_lamp_o            <= next_yel;
            outputs_frozen_o         <= module_fail_i && !offline;
            module_no_comm_message_o <= module_fail_i;
            slot_tens_o              <= next_tens;
            slot_ones_o              <= next_ones;
            act_lamp_o               <= next_act;
            duplex_lamp_o            <= net_live && link_up_i && full_duplex_i;
            speed_lamp_o             <= net_live && link_up_i && speed100_i;
            selftest_lamp_o          <= next_st;
            net_green_lamp_o         <= next_ngr;
            net_red_lamp_o           <= next_nrd;
            fault_lamp_o             <= next_fault;
            di_failsafe_o            <= mod_failsafe_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_severe;
        err_class_i == sli_pkg::ERR_SEVERE;
    endsequence

    property p_pwr_dark;
        @(posedge clk_i) disable iff (reset_i)
        s_severe |=> !power_ok_lamp_o;
    endproperty
    a_pwr_dark: assert property (p_pwr_dark) else $error("power lamp lit on severe error");

    property p_red_steady;
        @(posedge clk_i) disable iff (reset_i)
        !in_start && err_class_i == sli_pkg::ERR_100 |=> red_lamp_o;
    endproperty
    a_red_steady: assert property (p_red_steady) else $error("red lamp not steady");

    property p_clear;
        @(posedge clk_i) disable iff (reset_i)
        clear_now |=> err_clear_o;
    endproperty
    a_clear: assert property (p_clear) else $error("enter key did not clear");

    property p_yel_on;
        @(posedge clk_i) disable iff (reset_i)
        cpu_ready_i && comm_ok_i && !module_fail_i && !offline |=> yellow_lamp_o;
    endproperty
    a_yel_on: assert property (p_yel_on) else $error("yellow lamp dark on-line");

    property p_slot;
        @(posedge clk_i) disable iff (reset_i)
        module_fail_i && module_slot_i == 7'h2A |=>
            module_no_comm_message_o && slot_tens_o == 4'h4 && slot_ones_o == 4'h2;
    endproperty
    a_slot: assert property (p_slot) else $error("slot digits wrong");

    property p_act_dark;
        @(posedge clk_i) disable iff (reset_i)
        net_live && !link_up_i |=> !act_lamp_o;
    endproperty
    a_act_dark: assert property (p_act_dark) else $error("activity lamp lit without link");

    property p_pause;
        @(posedge clk_i) disable iff (reset_i)
        net_live && in_pause |=> !net_red_lamp_o;
    endproperty
    a_pause: assert property (p_pause) else $error("red lit during pause");

    property p_do;
        @(posedge clk_i) disable iff (reset_i)
        !do_active_i[0] |=> !do_lamp_o[0];
    endproperty
    a_do: assert property (p_do) else $error("inactive output lamp lit");

    property p_red_start;
        @(posedge clk_i) disable iff (reset_i)
        ctl_state == sli_pkg::SLI_START_B |=> !red_lamp_o;
    endproperty
    a_red_start: assert property (p_red_start) else $error("red lit in dark start step");

    sequence s_net_first;
        net_state == sli_pkg::SLI_NET_S1;
    endsequence

    property p_net_first;
        @(posedge clk_i) disable iff (reset_i)
        s_net_first |=> selftest_lamp_o && net_green_lamp_o && net_red_lamp_o;
    endproperty
    a_net_first: assert property (p_net_first) else $error("first network step wrong");

    property p_ai_good;
        @(posedge clk_i) disable iff (reset_i)
        ai_good_i[0] && !ai_err_i[0] |=> ai_lamp_o[0];
    endproperty
    a_ai_good: assert property (p_ai_good) else $error("good input loop lamp dark");

    property p_di_high;
        @(posedge clk_i) disable iff (reset_i)
        di_level_i[0] |=> di_lamp_o[0];
    endproperty
    a_di_high: assert property (p_di_high) else $error("high input lamp dark");
endmodule : sli_lamps
`default_nettype wire

// >>> tb/sli_panel.sv
// Operator faceplate model: turns a key press into a one-cycle enter pulse.
`timescale 1ns/1ps
`default_nettype none
module sli_panel (
    input  wire logic clk_i,   // System clock.
    input  wire logic press_i, // Operator holds the enter key.
    output logic      enter_o  // Enter pulse to the lamp logic.
);
    logic held = 1'b0;
    always_ff @(posedge clk_i) begin
        held    <= press_i;
        enter_o <= press_i & ~held;
    end
endmodule : sli_panel
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the status lamp logic.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned TK = 10;
    logic       clk_i = 1'b0, reset_i = 1'b1, press = 1'b0, cpu = 1'b1, comm = 1'b1, mfail = 1'b0;
    logic       link = 1'b1, act = 1'b0, fdx = 1'b0, s100 = 1'b0, tdone = 1'b1, fs = 1'b0;
    logic       aerr = 1'b0, mst = 1'b0, flt = 1'b0, enter;
    logic [1:0] err = 2'h0;
    logic [6:0] slot = 7'h00;
    logic [2:0] code = 3'h0;
    logic [7:0] aig = 8'h00, aia = 8'h00, aie = 8'h00, aog = 8'h00, aoa = 8'h00, aoe = 8'h00;
    logic [7:0] dil = 8'h00, dol = 8'h00, doa = 8'h00, dlen = 8'h00, ail, aol, dill, doll, dact;
    logic       power_ok_lamp, red, yel, clr, frz, msg, actl, dup, spd, stl, ngr, nrd, fltl, dfs;
    logic [3:0] tens, ones;
    int         err_count = 0, compares = 0, k;

    sli_panel sli_panel_inst (.clk_i(clk_i), .press_i(press), .enter_o(enter));
    sli_lamps #(.TICK_CYCLES(TK), .CHANNELS(8)) sli_lamps_inst (
        .clk_i(clk_i), .reset_i(reset_i), .err_class_i(err), .cpu_ready_i(cpu),
        .comm_ok_i(comm), .module_fail_i(mfail), .module_slot_i(slot), .enter_i(enter),
        .link_up_i(link), .link_act_i(act), .full_duplex_i(fdx), .speed100_i(s100),
        .net_test_done_i(tdone), .net_err_code_i(code), .mod_failsafe_i(fs),
        .mod_fault_i(flt), .mod_addr_err_i(aerr), .mod_startup_i(mst), .ai_good_i(aig),
        .ai_active_i(aia), .ai_err_i(aie), .ao_good_i(aog), .ao_active_i(aoa), .ao_err_i(aoe),
        .di_level_i(dil), .di_latch_en_i(dlen), .do_level_i(dol), .do_active_i(doa),
        .power_ok_lamp_o(power_ok_lamp), .red_lamp_o(red), .yellow_lamp_o(yel), .err_clear_o(clr),
        .outputs_frozen_o(frz), .module_no_comm_message_o(msg), .slot_tens_o(tens),
        .slot_ones_o(ones), .act_lamp_o(actl), .duplex_lamp_o(dup), .speed_lamp_o(spd),
        .selftest_lamp_o(stl), .net_green_lamp_o(ngr), .net_red_lamp_o(nrd),
        .fault_lamp_o(fltl), .ai_lamp_o(ail), .ao_lamp_o(aol), .di_lamp_o(dill),
        .do_lamp_o(doll), .di_failsafe_o(dfs), .di_active_o(dact));

    // Returns the lamp whose transitions are being counted.
    function automatic logic lamp(input logic [2:0] s);
        case (s)
            3'h0: return red;
            3'h1: return yel;
            3'h2: return actl;
            3'h3: return nrd;
            3'h4: return fltl;
            3'h5: return ail[0];
            default: return aol[0];
        endcase
    endfunction : lamp

    initial begin
        forever #4 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t lamp value %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic toggles(input logic [2:0] s, input int n, output int t);
        logic last;
        t = 0;
        repeat (n) begin
            last = lamp(s);
            cyc(1);
            t += (lamp(s) !== last) ? 1 : 0;
        end
    endtask : toggles
    task automatic test_done();
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_controller();
        err = 2'h1; cyc(3); check(red, 1);
        err = 2'h3; cyc(3); check(power_ok_lamp, 0);
        err = 2'h0; cyc(3); check({power_ok_lamp, yel}, 8'h03);
        err = 2'h2; toggles(3'h0, 6 * TK, k); check(k >= 4, 1);
        press = 1'b1; k = 0;
        repeat (8) begin
            cyc(1);
            k += clr;
        end
        check(k, 1);
        press = 1'b0; err = 2'h0; mfail = 1'b1; slot = 7'h2A; cyc(3);
        check({msg, frz, 6'h00}, 8'hC0);
        check({tens, ones}, 8'h42);
        check(tens, 4);
        toggles(3'h1, 6 * TK, k); check(k >= 4, 1);
        mfail = 1'b0; cyc(3);
    endtask : t_controller
    task automatic t_network();
        fdx = 1'b1; cyc(3); check({actl, dup, spd, stl}, 8'h0C);
        act = 1'b1; toggles(3'h2, 6 * TK, k); check(k >= 4, 1);
        act = 1'b0; fdx = 1'b0; s100 = 1'b1; cyc(3);
        check({actl, dup, spd}, 8'h05);
        link = 1'b0; cyc(3);
        check({actl, dup, spd}, 8'h00);
        for (int n = 1; n <= 6; n++) begin
            code = 3'(n); cyc((2 * n + 5) * TK);
            toggles(3'h3, 2 * (2 * n + 5) * TK, k); check(k, 4 * n);
        end
        code = 3'h0; cyc(20 * TK); check(nrd, 0);
    endtask : t_network
    task automatic t_modules();
        fs = 1'b1; cyc(3); check(fltl, 1); fs = 1'b0; cyc(3); check(fltl, 0);
        aerr = 1'b1; toggles(3'h4, 6 * TK, k); check(k >= 4, 1); aerr = 1'b0;
        flt = 1'b1; cyc(3); check(fltl, 1); flt = 1'b0;
        mst = 1'b1; toggles(3'h4, 6 * TK, k); check(k >= 4, 1); mst = 1'b0;
        aig = 8'hFF; aog = 8'hFF; cyc(3); check({ail, aol} == 16'hFFFF, 1);
        aig = 8'h00; aog = 8'h00; cyc(3); check(ail | aol, 0);
        aia = 8'h01; toggles(3'h5, 6 * TK, k); check(k >= 4, 1);
        aoa = 8'h01; toggles(3'h6, 6 * TK, k); check(k >= 4, 1);
        aia = 8'h00; aig = 8'h01; aie = 8'h01;
        toggles(3'h5, 6 * TK, k); check(k >= 4, 1);
        dil = 8'h5A; dol = 8'hFF; doa = 8'h0F; cyc(3);
        check(dill, 8'h5A);
        check(doll, 8'h0F);
        dlen = 8'h01; dil = 8'h01; cyc(3); dil = 8'h00; cyc(3);
        check(dill, 8'h01);
        dlen = 8'h00; cyc(3);
        check(dill, 8'h00);
    endtask : t_modules
    task automatic t_powerup();
        reset_i = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        cyc(2);
        check({stl, ngr, nrd, actl}, 8'h0E);
        cyc(TK);
        check({stl, ngr, nrd, actl}, 8'h03);
        cyc(TK);
        check({stl, ngr, nrd, actl}, 8'h0C);
        cyc(TK);
        check({stl, ngr, nrd, actl}, 8'h04);
        comm = 1'b0;
        toggles(3'h1, 6 * TK, k); check(k >= 4, 1);
        comm = 1'b1;
    endtask : t_powerup
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        check(dact, 8'hFF);
        check(dfs, 0);
        check({power_ok_lamp, red, yel, fltl, actl}, 0);
        reset_i = 1'b0;
        toggles(3'h0, 8 * TK, k); check(k, 4);
        t_controller();
        t_network();
        t_modules();
        t_powerup();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
